// ===== core/wii_pkg.sv
// package for the weld initiation input logic: constants, modes and carriers
// assumes a single 40 MHz system clock and active-low asynchronous reset
package wii_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int FLASH_MS = 250;
    localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_MS;
    localparam logic [7:0] SCHED_SECOND = 8'h14; // schedule 20
    localparam logic [7:0] SCHED_THIRD = 8'h28; // schedule 40
    localparam logic [7:0] MODE_NORMAL = 8'h00;
    localparam logic [7:0] MODE_EXT_SELECT = 8'h01;
    localparam logic [7:0] MODE_ANTI_TIE = 8'h02;
    localparam int INPUT_COUNT = 9;
    localparam int IDX_FIRST = 0;
    localparam int IDX_PRIMARY = 1;
    localparam int IDX_SECOND = 2;
    localparam int IDX_THIRD = 3;
    localparam int IDX_PRESSURE = 4;
    localparam int IDX_ESTOP = 5;
    localparam int IDX_PERMIT = 6;
    localparam int IDX_WATER = 7;
    localparam int IDX_SPARE = 8;
    localparam int EV_START = 0;
    localparam int EV_ESTOP = 1;
    localparam int EV_WATER = 2;
    localparam int EV_PRESSURE = 3;
    localparam int EV_COUNT = 4;
    // closed contacts after debounce
    typedef struct packed {
        logic spare;
        logic waterFlow;
        logic weldPermit;
        logic estopClosed;
        logic pressureOk;
        logic thirdPilot;
        logic secondPilot;
        logic primaryPilot;
        logic firstStage;
    } wii_contacts_type;
    // request to the sequence timer
    typedef struct packed {
        logic start;
        logic [7:0] schedule;
    } wii_start_type;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SQUEEZE, ST_PRESSURE_WAIT, ST_WELD, ST_HOLD_OFF, ST_STOPPED
    } wii_state_type;
endpackage

// ===== core/wii_initiation.sv
// initiation and interlock logic of a resistance welding control
// assumes contact inputs are low when closed to common, pulled high when open,
// and a sequence timer that reports squeeze, weld and sequence done by pulses
`timescale 1ns/1ps
`default_nettype none
module wii_initiation
    import wii_pkg::*;
#(
    parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES,
    parameter int FLASH_COUNT = FLASH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [INPUT_COUNT-1:0] contactPins,
    input wire logic [7:0] displaySchedule,
    input wire logic [7:0] selectBase,
    input wire logic [7:0] initMode,
    input wire logic twoStageMode,
    input wire logic repeatMode,
    input wire logic squeezeDone,
    input wire logic weldDone,
    input wire logic sequenceDone,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    output logic [7:0] startSchedule,
    output logic startPulse,
    output logic valvesFirstStage,
    output logic weldEnable,
    output logic squeezeLamp,
    output logic estopActive,
    output logic waterFault,
    output logic sequenceActive,
    output logic irq
);
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_CONTACTS = 8'h08;
    localparam int CNT_W = $clog2(DEBOUNCE_COUNT + 1);
    localparam int FL_W = $clog2(FLASH_COUNT + 1);

    initial begin
        if (DEBOUNCE_COUNT < 1 || FLASH_COUNT < 1) begin
            $error("wii_initiation: counts must be at least one");
        end
        // contact readback and event bits must each fit in the 32-bit data word
        if (INPUT_COUNT > 32 || EV_COUNT > 32) begin
            $error("wii_initiation: readback wider than the data word");
        end
        // pilot and interlock slots are fixed by the carrier layout
        if (INPUT_COUNT != $bits(wii_contacts_type)) begin
            $error("wii_initiation: contact count does not match the carrier");
        end
        // start and stop, and water and pressure events, must not share an event bit
        if (EV_START == EV_ESTOP || EV_WATER == EV_PRESSURE) begin
            $error("wii_initiation: event bits overlap");
        end
    end

    // three-stage synchroniser and debounce per contact
    logic [INPUT_COUNT-1:0] syncA_reg, syncB_reg, syncC_reg;
    logic [INPUT_COUNT-1:0] stable_reg;
    logic [CNT_W-1:0] dbCnt_reg [INPUT_COUNT];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= '1;
            syncB_reg <= '1;
            syncC_reg <= '1;
        end else begin
            syncA_reg <= contactPins;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < INPUT_COUNT; g++) begin : gDeb
            wire agree = (syncB_reg[g] == syncC_reg[g]);
            wire differs = agree && (syncC_reg[g] != stable_reg[g]);
            // a change must hold for the debounce window
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dbCnt_reg[g] <= '0;
                    stable_reg[g] <= 1'b1;
                end else if (!differs) begin
                    dbCnt_reg[g] <= '0;
                end else if (dbCnt_reg[g] == CNT_W'(DEBOUNCE_COUNT - 1)) begin
                    dbCnt_reg[g] <= '0;
                    stable_reg[g] <= syncC_reg[g];
                end else begin
                    dbCnt_reg[g] <= dbCnt_reg[g] + 1'b1;
                end
            end
        end
    endgenerate

    // low level means closed to common
    wii_contacts_type closed;
    assign closed = wii_contacts_type'(~stable_reg);

    // mode decode
    wire extSelect = (initMode == MODE_EXT_SELECT);
    wire antiTie = (initMode == MODE_ANTI_TIE);
    wire estopNow = !closed.estopClosed;
    wire waterOpen = !closed.waterFlow;

    // pilot edges, previous levels kept for a fresh-closure check
    logic prevPrimary_reg, prevSecond_reg, prevThird_reg, prevAnti_reg;
    wire antiBoth = closed.secondPilot && closed.thirdPilot;
    wire primRise = closed.primaryPilot && !prevPrimary_reg;
    wire secRise = closed.secondPilot && !prevSecond_reg;
    wire thrRise = closed.thirdPilot && !prevThird_reg;
    wire antiRise = antiBoth && !prevAnti_reg;
    wire multiPilot = !extSelect && !antiTie;

    // schedule chosen by the initiating input
    wire [1:0] pointer = {closed.thirdPilot, closed.secondPilot};
    wire [7:0] pointedSchedule = selectBase + {6'h00, pointer};
    wire freshStart = primRise || (multiPilot && (secRise || thrRise)) || (antiTie && antiRise);
    wire [7:0] freshSchedule =
        (antiTie && antiRise) ? displaySchedule :
        primRise ? (extSelect ? pointedSchedule : displaySchedule) :
        secRise ? SCHED_SECOND :
        SCHED_THIRD;

    // repeat continuation, held levels instead of edges
    wire pilotHeld = antiTie ? antiBoth :
        (closed.primaryPilot || (multiPilot && (closed.secondPilot || closed.thirdPilot)));
    wire repeatHold = twoStageMode ? (pilotHeld || closed.firstStage) : pilotHeld;

    // sequencing state
    wii_state_type state_reg, state_next;
    logic [7:0] lastSchedule_reg;
    logic start_next;
    logic [7:0] sched_next;
    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        sched_next = lastSchedule_reg;
        case (state_reg)
            ST_IDLE: begin
                if (freshStart && !waterOpen) begin
                    state_next = ST_SQUEEZE;
                    start_next = 1'b1;
                    sched_next = freshSchedule;
                end
            end
            ST_SQUEEZE: begin
                if (squeezeDone) begin
                    state_next = closed.pressureOk ? ST_WELD : ST_PRESSURE_WAIT;
                end
            end
            ST_PRESSURE_WAIT: begin
                if (closed.pressureOk) begin
                    state_next = ST_WELD;
                end
            end
            ST_WELD: begin
                if (weldDone) begin
                    state_next = ST_HOLD_OFF;
                end
            end
            ST_HOLD_OFF: begin
                if (sequenceDone) begin
                    if (repeatMode && repeatHold && !waterOpen) begin
                        state_next = ST_SQUEEZE;
                        start_next = 1'b1;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_STOPPED: begin
                state_next = ST_STOPPED;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // a stop overrides everything, including a start decoded this cycle
        if (estopNow) begin
            state_next = ST_STOPPED;
            start_next = 1'b0;
            sched_next = lastSchedule_reg;
        end else if (state_reg == ST_STOPPED) begin
            state_next = ST_IDLE;
        end
    end

    // state and edge history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            lastSchedule_reg <= 8'h00;
            prevPrimary_reg <= 1'b1;
            prevSecond_reg <= 1'b1;
            prevThird_reg <= 1'b1;
            prevAnti_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            lastSchedule_reg <= sched_next;
            // while stopped, history stays set so a held pilot needs reclosing
            prevPrimary_reg <= closed.primaryPilot || estopNow;
            prevSecond_reg <= closed.secondPilot || estopNow;
            prevThird_reg <= closed.thirdPilot || estopNow;
            prevAnti_reg <= antiBoth || estopNow;
        end
    end

    // squeeze lamp flash timer
    logic [FL_W-1:0] flashCnt_reg;
    logic flash_reg;
    wire waiting = (state_reg == ST_PRESSURE_WAIT);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flashCnt_reg <= '0;
            flash_reg <= 1'b0;
        end else if (!waiting) begin
            flashCnt_reg <= '0;
            flash_reg <= 1'b0;
        end else if (flashCnt_reg == FL_W'(FLASH_COUNT - 1)) begin
            flashCnt_reg <= '0;
            flash_reg <= !flash_reg;
        end else begin
            flashCnt_reg <= flashCnt_reg + 1'b1;
        end
    end

    // next values of the outputs, decoded ahead of their registers
    wire inSeq = (state_reg != ST_IDLE) && (state_reg != ST_STOPPED);
    wire lampNext = (state_next == ST_SQUEEZE) || (waiting && flash_reg);
    wire valvesNext = twoStageMode && closed.firstStage && !inSeq && !estopNow;
    // current only in weld, permit closed and no stop, so a dropout cuts it
    wire weldNext = (state_next == ST_WELD) && closed.weldPermit && !estopNow;
    wire activeNext = (state_next != ST_IDLE) && (state_next != ST_STOPPED);

    // start request towards the sequence timer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            startPulse <= 1'b0;
            startSchedule <= 8'h00;
        end else begin
            startPulse <= start_next;
            startSchedule <= sched_next;
        end
    end

    // level outputs, all straight from flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            valvesFirstStage <= 1'b0;
            weldEnable <= 1'b0;
            squeezeLamp <= 1'b0;
            estopActive <= 1'b0;
            waterFault <= 1'b0;
            sequenceActive <= 1'b0;
        end else begin
            valvesFirstStage <= valvesNext;
            weldEnable <= weldNext;
            squeezeLamp <= lampNext;
            estopActive <= estopNow;
            waterFault <= waterOpen;
            sequenceActive <= activeNext;
        end
    end

    // sticky events, mask and interrupt
    logic [EV_COUNT-1:0] status_reg, mask_reg;
    logic estopPrev_reg, waterPrev_reg;
    wire [EV_COUNT-1:0] events;
    assign events[EV_START] = start_next;
    assign events[EV_ESTOP] = estopNow && !estopPrev_reg;
    assign events[EV_WATER] = waterOpen && !waterPrev_reg;
    // pressure event marks entry into the wait, once per squeeze
    assign events[EV_PRESSURE] = (state_next == ST_PRESSURE_WAIT) && !waiting;
    wire wrStatus = regWrite && (regAddr == ADDR_STATUS);
    wire wrMask = regWrite && (regAddr == ADDR_MASK);
    wire [EV_COUNT-1:0] clearBits = wrStatus ? regWrData[EV_COUNT-1:0] : '0;
    // set wins over a clear landing in the same cycle
    wire [EV_COUNT-1:0] status_next = (status_reg & ~clearBits) | events;
    wire [EV_COUNT-1:0] mask_next = wrMask ? regWrData[EV_COUNT-1:0] : mask_reg;
    wire irqNext = |(status_next & mask_next);
    wire [31:0] rdMux =
        (regAddr == ADDR_STATUS) ? {{(32-EV_COUNT){1'b0}}, status_reg} :
        (regAddr == ADDR_MASK) ? {{(32-EV_COUNT){1'b0}}, mask_reg} :
        (regAddr == ADDR_CONTACTS) ? {{(32-INPUT_COUNT){1'b0}}, closed} :
        32'h0000_0000;
    // read data stand only in the cycle after the read strobe
    wire [31:0] rdNext = regRead ? rdMux : 32'h0000_0000;

    // status, mask and onset history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= '0;
            mask_reg <= '0;
            estopPrev_reg <= 1'b0;
            waterPrev_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            estopPrev_reg <= estopNow;
            waterPrev_reg <= waterOpen;
        end
    end

    // read port and interrupt level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            regRdData <= rdNext;
            irq <= irqNext;
        end
    end
endmodule
`default_nettype wire

// ===== dv/wii_switch_model.sv
// operator pilot switches and process contacts facing the initiation block
// assumes a closed contact ties its pin to common and an open one floats high
`timescale 1ns/1ps
`default_nettype none
module wii_switch_model (
    input wire logic [8:0] closed,
    input wire logic [2:0] stopChain,
    output logic [8:0] contactPins
);
    // floating pins read high; the series stop chain opens on any one switch
    always_comb begin
        contactPins = ~closed;
        contactPins[5] = ~&stopChain;
    end
endmodule
`default_nettype wire

// ===== dv/wii_initiation_sva.sv
// port checks for the initiation block
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module wii_initiation_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] startSchedule,
    input wire logic startPulse,
    input wire logic twoStageMode,
    input wire logic sequenceDone,
    input wire logic valvesFirstStage,
    input wire logic weldEnable,
    input wire logic estopActive,
    input wire logic waterFault,
    input wire logic sequenceActive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // steps of a run as seen at the ports
    sequence launch; startPulse; endsequence
    sequence running; (sequenceActive && !sequenceDone)[*3]; endsequence
    sequence stopHeld; estopActive ##1 estopActive; endsequence
    sequence dry; waterFault ##1 waterFault; endsequence
    AST_PULSE_ONE: assert property (launch |=> !startPulse)
        else $error("start pulse wider than one cycle");
    AST_START_BUSY: assert property (launch |-> sequenceActive)
        else $error("start without an active sequence");
    AST_LATCH: assert property (running |=> !startPulse)
        else $error("start while a sequence runs");
    AST_STOP: assert property (stopHeld |-> !weldEnable && !valvesFirstStage && !startPulse)
        else $error("output left on during stop");
    AST_WELD_BUSY: assert property (weldEnable |-> sequenceActive && !estopActive)
        else $error("weld current outside a sequence");
    AST_DRY: assert property (dry |-> !startPulse)
        else $error("start with water open");
    AST_VALVES: assert property (valvesFirstStage |-> $past(twoStageMode))
        else $error("first stage valves out of mode");
    AST_SCHED: assert property ($changed(startSchedule) |-> startPulse)
        else $error("schedule changed without a start");
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the weld initiation block
// assumes short debounce and flash counts to keep runs brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wii_pkg::*;
    localparam int SET = 12;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic two = 1'b0;
    logic rep = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] chain = 3'h7;
    logic [2:0] tmr = 3'h0;
    logic [8:0] sw = 9'h0F0;
    logic [8:0] pins;
    logic [7:0] disp = 8'h07;
    logic [7:0] base = 8'h30;
    logic [7:0] mode = 8'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] sched;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] d;
    logic stp, valves, weld, lamp, stop, water, busy, irq;
    int failures = 0;
    int check_count = 0;
    int n;
    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;
    wii_switch_model i_wii_switch_model (.closed(sw), .stopChain(chain), .contactPins(pins));
    wii_initiation #(.DEBOUNCE_COUNT(4), .FLASH_COUNT(8)) i_wii_initiation (
        .sys_clk(sys_clk), .rst_n(rst_n), .contactPins(pins), .displaySchedule(disp),
        .selectBase(base), .initMode(mode), .twoStageMode(two), .repeatMode(rep),
        .squeezeDone(tmr[0]), .weldDone(tmr[1]), .sequenceDone(tmr[2]), .regAddr(addr),
        .regWrData(wdat), .regWrite(wr), .regRead(rd), .regRdData(rdat),
        .startSchedule(sched), .startPulse(stp), .valvesFirstStage(valves),
        .weldEnable(weld), .squeezeLamp(lamp), .estopActive(stop), .waterFault(water),
        .sequenceActive(busy), .irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    // count start pulses over a bounded window
    task automatic starts(input int c);
        n = 0;
        repeat (c) begin
            if (stp === 1'b1) n++;
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic pilot(input int i, input logic v);
        @(posedge sys_clk);
        sw[i] <= v;
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge sys_clk);
        tmr <= v;
        @(posedge sys_clk);
        tmr <= 3'h0;
        #1;
    endtask
    // one register access; read data stand in the following cycle
    task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdat <= v;
        wr <= w;
        rd <= !w;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask
    task automatic launch(input int i, input logic [7:0] e);
        pilot(i, 1'b1);
        starts(SET);
        chk(n, 1);
        chk(sched, e);
        pilot(i, 1'b0);
    endtask
    task automatic finish;
        pulse(3'h1);
        tick(2);
        chk(weld, 1'b1);
        pulse(3'h2);
        pulse(3'h4);
        tick(SET);
    endtask
    task automatic rerun(input int i, input int e);
        pulse(3'h1);
        pulse(3'h2);
        pulse(3'h4);
        starts(SET);
        chk(n, e);
        if (i >= 0) pilot(i, 1'b0);
        tick(SET);
    endtask
    // each pilot starts its own schedule and the latch refuses a reclosure
    task automatic t_pilots;
        logic [7:0] e[3];
        e = '{disp, SCHED_SECOND, SCHED_THIRD};
        for (int i = 0; i < 3; i++) begin
            launch(i + 1, e[i]);
            tick(SET);
            pilot(i + 1, 1'b1);
            starts(SET);
            chk(n, 0);
            pilot(i + 1, 1'b0);
            finish;
        end
    endtask
    // second and third pilots point at one of four schedules
    task automatic t_select;
        @(posedge sys_clk);
        mode <= MODE_EXT_SELECT;
        for (int p = 0; p < 4; p++) begin
            pilot(2, p[0]);
            pilot(3, p[1]);
            tick(SET);
            launch(1, base + 8'(p));
            pilot(2, 1'b0);
            pilot(3, 1'b0);
            finish;
        end
        mode <= MODE_ANTI_TIE;
        pilot(2, 1'b1);
        starts(SET);
        chk(n, 0);
        launch(3, disp);
        pilot(2, 1'b0);
        finish;
        mode <= MODE_NORMAL;
    endtask
    // open water refuses starts and raises a masked event
    task automatic t_water;
        reg_io(1'b1, 8'h04, 32'h4);
        pilot(7, 1'b0);
        tick(SET);
        reg_io(1'b0, 8'h08, 32'h0);
        chk(d, 32'h070);
        chk({water, irq}, 2'h3);
        pilot(1, 1'b1);
        starts(SET);
        chk(n, 0);
        pilot(1, 1'b0);
        pilot(7, 1'b1);
        tick(SET);
        reg_io(1'b1, 8'h00, 32'h4);
        tick(2);
        chk(irq, 1'b0);
        reg_io(1'b0, 8'h0C, 32'h0);
        chk(d, 32'h0);
    endtask
    // a stop ends the run and a held pilot does not restart it
    task automatic t_estop;
        pilot(1, 1'b1);
        starts(SET);
        chk(n, 1);
        chain <= 3'h5;
        tick(SET);
        chk({stop, weld}, 2'h2);
        chain <= 3'h7;
        starts(SET + 4);
        chk(n, 0);
        pilot(1, 1'b0);
        tick(SET);
        launch(1, disp);
        finish;
    endtask
    // missing pressure holds the weld; an open permit drops current
    task automatic t_pressure;
        pilot(4, 1'b0);
        tick(SET);
        launch(1, disp);
        chk(lamp, 1'b1);
        pulse(3'h1);
        n = 0;
        repeat (24) begin
            tick(1);
            if (lamp === 1'b1) n++;
        end
        chk((n > 4) && (n < 20), 1'b1);
        chk({weld, busy}, 2'h1);
        reg_io(1'b0, 8'h00, 32'h0);
        chk(d[3], 1'b1);
        pilot(4, 1'b1);
        tick(SET);
        chk(weld, 1'b1);
        pilot(6, 1'b0);
        tick(SET);
        chk(weld, 1'b0);
        pilot(6, 1'b1);
        pulse(3'h2);
        pulse(3'h4);
        tick(SET);
    endtask
    // repeat keeps sequencing while a pilot, or in two-stage mode the first stage, is held
    task automatic t_repeat;
        rep <= 1'b1;
        pilot(1, 1'b1);
        starts(SET);
        chk(n, 1);
        rerun(1, 1);
        rerun(-1, 0);
        two <= 1'b1;
        pilot(0, 1'b1);
        tick(SET);
        chk(valves, 1'b1);
        launch(1, disp);
        rerun(0, 1);
        rerun(-1, 0);
        rep <= 1'b0;
        two <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence after a three cycle reset
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(SET);
        t_pilots;
        t_select;
        t_water;
        t_estop;
        t_pressure;
        t_repeat;
        wrap_up;
    end
    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        wrap_up;
    end
endmodule
bind wii_initiation wii_initiation_sva i_wii_initiation_sva (.sys_clk(sys_clk),
    .rst_n(rst_n), .startSchedule(startSchedule), .startPulse(startPulse),
    .twoStageMode(twoStageMode), .sequenceDone(sequenceDone),
    .valvesFirstStage(valvesFirstStage), .weldEnable(weldEnable),
    .estopActive(estopActive), .waterFault(waterFault), .sequenceActive(sequenceActive));
`default_nettype wire
